// file: logic/msc_pkg.sv
package msc_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] MODE_OFFSET = 8'h00;
  localparam logic [7:0] STATE_OFFSET = 8'h04;
  localparam logic [7:0] QUALITY_OFFSET = 8'h08;
  localparam logic [7:0] COMMAND_OFFSET = 8'h0c;
  // ==========================================================
  // operating_mode field positions
  localparam int MODE_IRQ_EN_BIT = 7;
  localparam int MODE_TX_BIT = 5;
  localparam int MODE_EYE_BIT = 4;
  localparam int MODE_POWERSAVE_BIT = 3;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // ==========================================================
  // modem_state field positions
  localparam int STATE_IRQ_BIT = 7;
  localparam int STATE_FREE_BIT = 6;
  localparam int STATE_IEMPTY_BIT = 5;
  localparam int STATE_OVF_BIT = 4;
  localparam int STATE_CHECKSUM_ERROR_BIT = 3;
  // ==========================================================
  // command layout: task code in low nibble, checksum preset select
  localparam int CMD_CRC_SEL_BIT = 5;
  localparam int CMD_TASK_LSB = 0;
  localparam int TASK_W = 4;
  // ==========================================================
  // task codes
  typedef enum logic [3:0] {
    TASK_NULL = 4'h0,
    TASK_RESET = 4'h1,
    TASK_FIND_SYNC = 4'h2,
    TASK_RX_HEADER = 4'h3,
    TASK_RX_MIDDLE_FINAL = 4'h4,
    TASK_RX_FOUR = 4'h5,
    TASK_TX_HEADER = 4'h6,
    TASK_TX_MIDDLE = 4'h7,
    TASK_TX_FINAL = 4'h8,
    TASK_TX_SYMBOLS = 4'h9
  } msc_task_type;
  // ==========================================================
  // coding and timing constants
  localparam int QUALITY_LSB = 3;
  localparam int QUALITY_W = 5;
  localparam int SETTLE_SYMBOLS = 20;
  localparam int BLOCK_BITS = 96;
  localparam int BLOCK_SYMBOLS = 66;
  localparam int ILEAVE_ROWS = 6;
  localparam int ILEAVE_COLS = 11;
  localparam logic [1:0] IEMPTY_THRESHOLD = 2'h2;
  localparam logic [15:0] CRC16_POLY = 16'h1021;
  localparam logic [31:0] CRC32_POLY = 32'h04c11db7;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : msc_pkg

// file: logic/msc_modem_status.sv
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
module msc_modem_status #(
  parameter int QUALITY_W = 5
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // axi4-lite write address and data
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // datapath events and status
  input wire logic i_symbol_tick,
  input wire logic i_task_done,
  input wire logic [6:0] i_ileave_count,
  input wire logic i_task_late,
  input wire logic i_crc_fail,
  input wire logic i_quality_valid,
  input wire logic [QUALITY_W-1:0] i_quality,
  // checksum byte stream
  input wire logic i_crc_byte_valid,
  input wire logic i_crc_byte_header,
  input wire logic [7:0] i_crc_byte,
  // datapath control
  output logic o_tx_mode,
  output logic o_eye_monitor,
  output logic o_powersave,
  output logic o_filters_settled,
  output logic o_task_abort,
  output logic o_task_start,
  output logic [3:0] o_task,
  output logic o_mid_level,
  output logic [6:0] o_ileave_addr,
  output logic [15:0] o_header_checksum,
  output logic [31:0] o_message_checksum,
  // interrupt pin, open drain
  output logic o_irq_n_out,
  output logic o_irq_n_oe
);
  // ==========================================================
  // reset synchroniser
  logic rst_meta_reg;
  logic rst_sync_n_reg;
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_n_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_n_reg <= rst_meta_reg;
    end
  end

  // ==========================================================
  // checksum update functions, msb first
  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ msc_pkg::CRC16_POLY) : (r << 1);
    end
    return r;
  endfunction : crc16_byte

  function automatic logic [31:0] crc32_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      r = (r[31] ^ d[i]) ? ((r << 1) ^ msc_pkg::CRC32_POLY) : (r << 1);
    end
    return r;
  endfunction : crc32_byte

  // receive-side data task codes (not find sync), used by overflow logic
  function automatic logic is_rx_data_task(input logic [3:0] t);
    return (t == msc_pkg::TASK_RX_HEADER) || (t == msc_pkg::TASK_RX_MIDDLE_FINAL) ||
           (t == msc_pkg::TASK_RX_FOUR);
  endfunction : is_rx_data_task

  // ==========================================================
  // bus slave state
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // one write in flight: accept each half until it is held, neither while a response waits
  assign o_awready = !aw_held_reg && !bvalid_reg;
  assign o_wready = !w_held_reg && !bvalid_reg;
  assign o_arready = !rvalid_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;

  wire aw_take = i_awvalid && o_awready;
  wire w_take = i_wvalid && o_wready;
  wire [7:0] wr_addr = aw_held_reg ? awaddr_reg : i_awaddr;
  wire [31:0] wr_data = w_held_reg ? wdata_reg : i_wdata;
  wire [3:0] wr_strb = w_held_reg ? wstrb_reg : i_wstrb;
  wire wr_fire = (aw_held_reg || aw_take) && (w_held_reg || w_take);
  wire wr_lane0 = wr_fire && wr_strb[0];
  wire wr_mode = wr_lane0 && (wr_addr == msc_pkg::MODE_OFFSET);
  wire wr_cmd = wr_lane0 && (wr_addr == msc_pkg::COMMAND_OFFSET);
  wire wr_known = (wr_addr == msc_pkg::MODE_OFFSET) || (wr_addr == msc_pkg::COMMAND_OFFSET);
  wire rd_fire = i_arvalid && o_arready;
  wire rd_state = rd_fire && (i_araddr == msc_pkg::STATE_OFFSET);

  // ==========================================================
  // mode register and command decode
  logic [7:0] mode_reg;
  logic crc_sel_reg;
  logic [3:0] task_reg;
  wire [7:0] mode_wdata = {wr_data[7:3], 3'h0}; // low bits kept zero
  wire mode_switch = wr_mode &&
    ((mode_wdata[msc_pkg::MODE_TX_BIT] != mode_reg[msc_pkg::MODE_TX_BIT]) ||
     (mode_wdata[msc_pkg::MODE_POWERSAVE_BIT] != mode_reg[msc_pkg::MODE_POWERSAVE_BIT]));
  wire [3:0] cmd_task = wr_data[msc_pkg::CMD_TASK_LSB +: msc_pkg::TASK_W];
  wire task_reset = wr_cmd && (cmd_task == msc_pkg::TASK_RESET);
  wire task_real = wr_cmd && (cmd_task != msc_pkg::TASK_NULL) &&
                   (cmd_task != msc_pkg::TASK_RESET);
  wire quiet_set = task_reset || mode_switch; // sets without interrupt
  wire tx_mode = mode_reg[msc_pkg::MODE_TX_BIT];

  // mode and command storage
  always_ff @(posedge i_sys_clk or negedge rst_sync_n_reg)
  begin
    if (!rst_sync_n_reg)
    begin
      mode_reg <= msc_pkg::MODE_RESET;
      crc_sel_reg <= 1'b0;
      task_reg <= msc_pkg::TASK_NULL;
    end
    else
    begin
      if (wr_mode)
        mode_reg <= mode_wdata;
      if (mode_switch)
        task_reg <= msc_pkg::TASK_NULL; // switch cancels work
      else if (wr_cmd)
        task_reg <= cmd_task;
      if (wr_cmd)
        crc_sel_reg <= wr_data[msc_pkg::CMD_CRC_SEL_BIT];
    end
  end

  // ==========================================================
  // powersave settle counter, counts symbols after powersave clears
  logic [4:0] settle_reg;
  wire powersave = mode_reg[msc_pkg::MODE_POWERSAVE_BIT];
  always_ff @(posedge i_sys_clk or negedge rst_sync_n_reg)
  begin
    if (!rst_sync_n_reg)
      settle_reg <= 5'h00;
    else if (powersave)
      settle_reg <= 5'h00;
    else if (i_symbol_tick && (settle_reg != 5'(msc_pkg::SETTLE_SYMBOLS)))
      settle_reg <= settle_reg + 5'h01;
  end

  // ==========================================================
  // status flags; hardware set wins over a read or task clear in the same cycle, not over a reset task or mode switch
  logic irq_reg;
  logic free_reg;
  logic iempty_reg;
  logic ovf_reg;
  logic checksum_error_reg;
  logic ie_hold_reg;
  logic ie_cond_reg;

  // interleave level below threshold, only meaningful in transmit
  wire ie_cond = tx_mode && !ie_hold_reg && (i_ileave_count < 7'(msc_pkg::IEMPTY_THRESHOLD));
  wire ie_rise = ie_cond && !ie_cond_reg && !iempty_reg;
  wire free_rise = i_task_done && !free_reg && !mode_switch;
  wire ovf_rise = !tx_mode && i_task_late && is_rx_data_task(task_reg) && !ovf_reg;
  wire irq_set = free_rise || ie_rise || ovf_rise;

  wire free_next = (i_task_done && !mode_switch) || quiet_set ||
                   (free_reg && !task_real);
  // judge against the mode being written, so a switch into transmit sets the flag quietly
  wire tx_next = wr_mode ? mode_wdata[msc_pkg::MODE_TX_BIT] : tx_mode;
  wire iempty_next = tx_next && (ie_rise || quiet_set ||
                     (iempty_reg && !ie_hold_reg && !task_real));
  wire ovf_next = !tx_mode && !quiet_set && (ovf_rise || (ovf_reg && !rd_state));
  wire crc_end = i_task_done && ((task_reg == msc_pkg::TASK_FIND_SYNC) ||
                 (task_reg == msc_pkg::TASK_RX_HEADER) ||
                 (task_reg == msc_pkg::TASK_RX_MIDDLE_FINAL));
  wire checksum_error_next = !tx_mode && !quiet_set &&
                     (crc_end ? i_crc_fail : checksum_error_reg);
  wire irq_next = irq_set || (irq_reg && !rd_state);

  // status flag storage
  always_ff @(posedge i_sys_clk or negedge rst_sync_n_reg)
  begin
    if (!rst_sync_n_reg)
    begin
      irq_reg <= 1'b0;
      free_reg <= 1'b1;
      iempty_reg <= 1'b0;
      ovf_reg <= 1'b0;
      checksum_error_reg <= 1'b0;
      ie_hold_reg <= 1'b0;
      ie_cond_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= irq_next;
      free_reg <= free_next;
      iempty_reg <= iempty_next;
      ovf_reg <= ovf_next;
      checksum_error_reg <= checksum_error_next;
      ie_cond_reg <= ie_cond;
      // hold the empty flag off until the next symbol after a task
      if (task_real)
        ie_hold_reg <= 1'b1;
      else if (i_symbol_tick)
        ie_hold_reg <= 1'b0;
    end
  end

  // ==========================================================
  // quality capture, receive mode only
  logic [QUALITY_W-1:0] quality_reg;
  always_ff @(posedge i_sys_clk or negedge rst_sync_n_reg)
  begin
    if (!rst_sync_n_reg)
      quality_reg <= '0;
    else if (tx_mode)
      quality_reg <= '0;
    else if (i_quality_valid)
      quality_reg <= i_quality;
  end

  // ==========================================================
  // checksum generators
  logic [15:0] crc16_reg;
  logic [31:0] crc32_reg;
  wire [15:0] crc16_preset = crc_sel_reg ? 16'h0000 : 16'hffff;
  wire [31:0] crc32_preset = crc_sel_reg ? 32'h00000000 : 32'hffffffff;
  // message checksum survives only across middle/final block tasks and while no task is set
  wire crc32_keep = (task_reg == msc_pkg::TASK_NULL) ||
    (!tx_mode && (task_reg == msc_pkg::TASK_RX_MIDDLE_FINAL)) ||
    (tx_mode && ((task_reg == msc_pkg::TASK_TX_MIDDLE) ||
                 (task_reg == msc_pkg::TASK_TX_FINAL)));
  wire crc32_init = (i_task_done && !crc32_keep) || task_reset || mode_switch;
  wire crc16_init = i_task_done || task_reset || mode_switch;

  // byte-serial update; datapath feeds only the covered bytes
  always_ff @(posedge i_sys_clk or negedge rst_sync_n_reg)
  begin
    if (!rst_sync_n_reg)
    begin
      crc16_reg <= 16'hffff;
      crc32_reg <= 32'hffffffff;
    end
    else
    begin
      if (crc16_init)
        crc16_reg <= crc16_preset;
      else if (i_crc_byte_valid && i_crc_byte_header)
        crc16_reg <= crc16_byte(crc16_reg, i_crc_byte);
      if (crc32_init)
        crc32_reg <= crc32_preset;
      else if (i_crc_byte_valid && !i_crc_byte_header)
        crc32_reg <= crc32_byte(crc32_reg, i_crc_byte);
    end
  end

  // ==========================================================
  // block symbol counter and interleave address
  logic [6:0] sym_reg;
  logic [2:0] row_reg;
  logic [3:0] col_reg;
  wire block_task = (task_reg == msc_pkg::TASK_TX_HEADER) ||
    (task_reg == msc_pkg::TASK_TX_MIDDLE) || (task_reg == msc_pkg::TASK_TX_FINAL) ||
    (task_reg == msc_pkg::TASK_RX_HEADER) || (task_reg == msc_pkg::TASK_RX_MIDDLE_FINAL) ||
    (task_reg == msc_pkg::TASK_FIND_SYNC);
  wire sym_last = (sym_reg == 7'(msc_pkg::BLOCK_SYMBOLS - 1));
  wire row_last = (row_reg == 3'(msc_pkg::ILEAVE_ROWS - 1));

  // symbols written by rows, read by columns: same order both ways
  always_ff @(posedge i_sys_clk or negedge rst_sync_n_reg)
  begin
    if (!rst_sync_n_reg)
    begin
      sym_reg <= 7'h00;
      row_reg <= 3'h0;
      col_reg <= 4'h0;
    end
    else if (task_real || mode_switch || !block_task || (i_symbol_tick && sym_last))
    begin
      sym_reg <= 7'h00;
      row_reg <= 3'h0;
      col_reg <= 4'h0;
    end
    else if (i_symbol_tick)
    begin
      sym_reg <= sym_reg + 7'h01;
      row_reg <= row_last ? 3'h0 : row_reg + 3'h1;
      col_reg <= row_last ? col_reg + 4'h1 : col_reg;
    end
  end

  // ==========================================================
  // bus slave registers
  wire [31:0] state_word = {24'h000000, irq_reg, free_reg, iempty_reg, ovf_reg,
                            checksum_error_reg, 3'h0};
  wire [31:0] quality_word = {24'h000000, quality_reg, 3'h0};
  // mode and command read back as zero: write only
  wire rd_known = (i_araddr == msc_pkg::MODE_OFFSET) ||
    (i_araddr == msc_pkg::STATE_OFFSET) || (i_araddr == msc_pkg::QUALITY_OFFSET) ||
    (i_araddr == msc_pkg::COMMAND_OFFSET);
  wire [31:0] rd_word = (i_araddr == msc_pkg::STATE_OFFSET) ? state_word :
                        (i_araddr == msc_pkg::QUALITY_OFFSET) ? quality_word : 32'h00000000;

  // write path: either half may arrive first
  always_ff @(posedge i_sys_clk or negedge rst_sync_n_reg)
  begin
    if (!rst_sync_n_reg)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= msc_pkg::AXI_OKAY;
    end
    else
    begin
      if (aw_take)
        awaddr_reg <= i_awaddr;
      if (w_take)
      begin
        wdata_reg <= i_wdata;
        wstrb_reg <= i_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_known ? msc_pkg::AXI_OKAY : msc_pkg::AXI_SLVERR;
      end
      else
      begin
        aw_held_reg <= aw_held_reg || aw_take;
        w_held_reg <= w_held_reg || w_take;
        if (bvalid_reg && i_bready)
          bvalid_reg <= 1'b0;
      end
    end
  end

  // read path: answer one cycle after the address is taken
  always_ff @(posedge i_sys_clk or negedge rst_sync_n_reg)
  begin
    if (!rst_sync_n_reg)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= msc_pkg::AXI_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_known ? msc_pkg::AXI_OKAY : msc_pkg::AXI_SLVERR;
    end
    else if (i_rready)
      rvalid_reg <= 1'b0;
  end

  // ==========================================================
  // datapath control pulses
  logic abort_reg;
  logic start_reg;
  always_ff @(posedge i_sys_clk or negedge rst_sync_n_reg)
  begin
    if (!rst_sync_n_reg)
    begin
      abort_reg <= 1'b0;
      start_reg <= 1'b0;
    end
    else
    begin
      abort_reg <= mode_switch || task_reset;
      start_reg <= task_real && !mode_switch;
    end
  end

  // ==========================================================
  // outputs
  assign o_tx_mode = tx_mode;
  assign o_eye_monitor = !tx_mode && mode_reg[msc_pkg::MODE_EYE_BIT];
  assign o_powersave = powersave;
  assign o_filters_settled = !powersave && (settle_reg == 5'(msc_pkg::SETTLE_SYMBOLS));
  assign o_task_abort = abort_reg;
  assign o_task_start = start_reg;
  assign o_task = task_reg;
  assign o_mid_level = tx_mode && iempty_reg;
  assign o_ileave_addr = 7'(col_reg) + 7'(row_reg) * 7'(msc_pkg::ILEAVE_COLS);
  assign o_header_checksum = crc16_reg;
  assign o_message_checksum = crc32_reg;
  // pin low while flag set and enabled; the read clears the flag
  assign o_irq_n_out = 1'b0;
  assign o_irq_n_oe = irq_reg && mode_reg[msc_pkg::MODE_IRQ_EN_BIT];
endmodule : msc_modem_status

// file: test/msc_dp_model.sv
// ========
// datapath stand-in facing the status block
module msc_dp_model (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // control from the block
  input wire logic i_tx_mode,
  input wire logic i_task_start,
  input wire logic i_task_abort,
  // events back to the block
  output logic o_symbol_tick,
  output logic o_task_done,
  output logic [6:0] o_ileave_count
);
  logic [2:0] div_reg;
  logic [5:0] busy_reg;
  // short symbol time keeps the run brief
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      div_reg <= 3'h0;
      o_symbol_tick <= 1'h0;
    end
    else
    begin
      div_reg <= div_reg + 3'h1;
      o_symbol_tick <= (div_reg == 3'h7);
    end
  end
  // a task takes 40 clocks; a send loads one whole coded block
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      busy_reg <= 6'h00;
      o_task_done <= 1'h0;
      o_ileave_count <= 7'h00;
    end
    else
    begin
      o_task_done <= (busy_reg == 6'h01);
      if (i_task_abort)
      begin
        busy_reg <= 6'h00;
        o_ileave_count <= 7'h00;
      end
      else if (i_task_start)
      begin
        busy_reg <= 6'h28;
        o_ileave_count <= i_tx_mode ? 7'h42 : 7'h00;
      end
      else
      begin
        busy_reg <= busy_reg - ((busy_reg != 6'h00) ? 6'h01 : 6'h00);
        if (o_symbol_tick && o_ileave_count != 7'h00)
          o_ileave_count <= o_ileave_count - 7'h01;
      end
    end
  end
endmodule : msc_dp_model

// file: test/msc_chk.sv
// ========
// port-level checks of the status block
module msc_chk (
  // clock, reset, bus
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [7:0] i_araddr,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  // datapath control and pin
  input wire logic o_tx_mode,
  input wire logic o_eye_monitor,
  input wire logic o_powersave,
  input wire logic o_filters_settled,
  input wire logic o_task_abort,
  input wire logic o_task_start,
  input wire logic o_mid_level,
  input wire logic o_irq_n_out,
  input wire logic o_irq_n_oe
);
  // write decode; halves taken apart are not judged here
  wire logic wr = i_awvalid && o_awready && i_wvalid && o_wready && i_wstrb[0];
  wire logic mw = wr && i_awaddr == msc_pkg::MODE_OFFSET;
  wire logic cw = wr && i_awaddr == msc_pkg::COMMAND_OFFSET;
  logic [7:0] ra_reg;
  logic ien_reg;
  // shadow of read address and interrupt enable
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ra_reg <= 8'h00;
      ien_reg <= 1'h0;
    end
    else
    begin
      ra_reg <= (i_arvalid && o_arready) ? i_araddr : ra_reg;
      ien_reg <= mw ? i_wdata[7] : ien_reg;
    end
  end
  default clocking dc @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_mode_tx: assert property (mw |=> o_tx_mode == $past(i_wdata[5]))
    else $error("tx mode not taken");
  a_switch_abort: assert property (mw &&
    (i_wdata[5] != o_tx_mode || i_wdata[3] != o_powersave) |=> o_task_abort)
    else $error("no abort");
  a_eye_rx: assert property (o_eye_monitor |-> !o_tx_mode)
    else $error("eye in tx");
  a_ps_unsettled: assert property (o_powersave |=> !o_filters_settled)
    else $error("settled in powersave");
  a_irq_pin: assert property (o_irq_n_oe |-> ien_reg && !o_irq_n_out)
    else $error("irq pin");
  a_task_start: assert property (cw && i_wdata[3:0] > 4'h1 |=> o_task_start)
    else $error("no task start");
  a_mid_tx: assert property (o_mid_level |-> o_tx_mode)
    else $error("mid level in rx");
  a_status_low: assert property (o_rvalid && ra_reg == msc_pkg::STATE_OFFSET |->
    o_rdata[2:0] == 3'h0 && (o_tx_mode ? o_rdata[4:3] == 2'h0 : !o_rdata[5]))
    else $error("status bits");
  a_quality_low: assert property (o_rvalid && ra_reg == msc_pkg::QUALITY_OFFSET |->
    o_rdata[2:0] == 3'h0) else $error("quality low bits");
  a_mode_wo: assert property (o_rvalid && ra_reg == msc_pkg::MODE_OFFSET |->
    o_rdata == 32'h0) else $error("mode readable");
endmodule : msc_chk
bind msc_modem_status msc_chk msc_chk_i (.i_sys_clk, .i_rst_n, .i_awaddr, .i_awvalid,
  .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .i_arvalid, .o_arready, .i_araddr,
  .o_rdata, .o_rvalid, .o_tx_mode, .o_eye_monitor, .o_powersave, .o_filters_settled,
  .o_task_abort, .o_task_start, .o_mid_level, .o_irq_n_out, .o_irq_n_oe);

// file: test/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // bench signals
  logic i_sys_clk = 1'h0, i_rst_n = 1'h0, i_awvalid = 1'h0, i_wvalid = 1'h0;
  logic i_arvalid = 1'h0, i_task_late = 1'h0, i_bready = 1'h1, i_rready = 1'h1;
  logic i_crc_fail = 1'h0, i_quality_valid = 1'h0, i_crc_byte_valid = 1'h0;
  logic i_crc_byte_header = 1'h0;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00, i_crc_byte = 8'h00;
  logic [31:0] i_wdata = 32'h0, seed = 32'h000063cf;
  logic [3:0] i_wstrb = 4'h1;
  logic [4:0] i_quality = 5'h00;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_tx_mode, o_eye_monitor;
  logic o_powersave, o_filters_settled, o_task_abort, o_task_start, o_mid_level;
  logic o_irq_n_out, o_irq_n_oe, i_symbol_tick, i_task_done;
  logic [1:0] o_bresp, o_rresp;
  logic [3:0] o_task;
  logic [6:0] i_ileave_count, o_ileave_addr;
  logic [15:0] o_header_checksum;
  logic [31:0] o_rdata, o_message_checksum, q;
  logic [65:0] e;
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  int fail_count = 0;
  int checks = 0;
  initial
  begin
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  msc_modem_status msc_modem_status_i (
    .i_sys_clk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid,
    .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
    .o_rresp, .o_rvalid, .i_rready, .i_symbol_tick, .i_task_done, .i_ileave_count,
    .i_task_late, .i_crc_fail, .i_quality_valid, .i_quality, .i_crc_byte_valid,
    .i_crc_byte_header, .i_crc_byte, .o_tx_mode, .o_eye_monitor, .o_powersave,
    .o_filters_settled, .o_task_abort, .o_task_start, .o_task, .o_mid_level, .o_ileave_addr,
    .o_header_checksum, .o_message_checksum, .o_irq_n_out, .o_irq_n_oe);
  msc_dp_model msc_dp_model_i (.i_sys_clk, .i_rst_n, .i_tx_mode(o_tx_mode),
    .i_task_start(o_task_start), .i_task_abort(o_task_abort), .o_symbol_tick(i_symbol_tick),
    .o_task_done(i_task_done), .o_ileave_count(i_ileave_count));
  // ========
  // helpers
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x)
    begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", n, x, s);
    end
  endtask : chk
  task stop_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // both halves offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    logic aw, w;
    bq.push_back(r);
    @(posedge i_sys_clk);
    i_awaddr <= a;
    i_wdata <= {24'h0, d};
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    aw = 1'h0;
    w = 1'h0;
    while (!(aw && w))
    begin
      @(posedge i_sys_clk);
      aw = aw | (i_awvalid & o_awready);
      w = w | (i_wvalid & o_wready);
      i_awvalid <= i_awvalid & !aw;
      i_wvalid <= i_wvalid & !w;
    end
    while (o_bvalid !== 1'h1) @(posedge i_sys_clk);
  endtask : wr
  task wm(input logic [7:0] d);
    wr(msc_pkg::MODE_OFFSET, d, msc_pkg::AXI_OKAY);
  endtask : wm
  task wc(input logic [7:0] d);
    wr(msc_pkg::COMMAND_OFFSET, d, msc_pkg::AXI_OKAY);
  endtask : wc
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({m, r, d});
    @(posedge i_sys_clk);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    do @(posedge i_sys_clk); while (o_arready !== 1'h1);
    i_arvalid <= 1'h0;
    while (o_rvalid !== 1'h1) @(posedge i_sys_clk);
  endtask : rd
  task rs(input logic [7:0] d);
    rd(msc_pkg::STATE_OFFSET, 32'hffffffff, {24'h0, d}, msc_pkg::AXI_OKAY);
  endtask : rs
  task wi;
    while (o_irq_n_oe !== 1'h1) @(posedge i_sys_clk);
  endtask : wi
  task cb(input logic h);
    for (int i = 0; i < 9; i++)
    begin
      @(posedge i_sys_clk);
      i_crc_byte_valid <= 1'h1;
      i_crc_byte_header <= h;
      i_crc_byte <= 8'h31 + 8'(i);
    end
    @(posedge i_sys_clk);
    i_crc_byte_valid <= 1'h0;
    repeat (2) @(posedge i_sys_clk);
  endtask : cb
  // answers compared with the oldest note
  always @(posedge i_sys_clk)
  begin
    if (o_rvalid && i_rready && rq.size() > 0)
    begin
      e = rq.pop_front();
      chk("rdata", o_rdata & e[65:34], e[31:0]);
      chk("rresp", 32'(o_rresp), 32'(e[33:32]));
    end
    if (o_bvalid && i_bready && bq.size() > 0)
      chk("bresp", 32'(o_bresp), 32'(bq.pop_front()));
  end
  initial
  begin
    #20000;
    fail_count++;
    stop_test;
  end
  // ========
  // scenarios
  initial
  begin
    repeat (20) @(posedge i_sys_clk);
    i_rst_n <= 1'h1;
    repeat (3) @(posedge i_sys_clk);
    rs(8'h40);
    rd(msc_pkg::MODE_OFFSET, 32'hffffffff, 32'h0, msc_pkg::AXI_OKAY);
    rd(8'h10, 32'h0, 32'h0, msc_pkg::AXI_SLVERR);
    wr(8'h10, 8'h00, msc_pkg::AXI_SLVERR);
    wm(8'ha0);
    chk("tx", 32'(o_tx_mode), 32'h1);
    rs(8'h60);
    wc(8'h07);
    rd(msc_pkg::STATE_OFFSET, 32'hdf, 32'h0, msc_pkg::AXI_OKAY);
    repeat (16) @(posedge i_sys_clk);
    rs(8'h00);
    wi;
    rs(8'hc0);
    @(posedge i_sys_clk);
    chk("irq_oe", 32'(o_irq_n_oe), 32'h0);
    wi;
    rs(8'he0);
    chk("mid", 32'(o_mid_level), 32'h1);
    wm(8'h80);
    chk("task", 32'(o_task), 32'h0);
    rs(8'h40);
    for (int k = 0; k < 2; k++)
    begin
      wc(k ? 8'h23 : 8'h03);
      wi;
      rs(8'hc0);
      cb(1'h1);
      chk("hdr", 32'(o_header_checksum), k ? 32'h31c3 : 32'h29b1);
      cb(1'h0);
      chk("msg", o_message_checksum, k ? 32'h89a1897f : 32'h0376e6e7);
    end
    i_crc_fail <= 1'h1;
    wc(8'h03);
    wi;
    rs(8'hc8);
    wc(8'h04);
    i_task_late <= 1'h1;
    @(posedge i_sys_clk);
    i_task_late <= 1'h0;
    wi;
    rs(8'h98);
    rs(8'h08);
    wi;
    rs(8'hc8);
    wc(8'h01);
    rs(8'h40);
    chk("addr", 32'(o_ileave_addr), 32'h0);
    q = xs();
    i_quality <= q[4:0];
    i_quality_valid <= 1'h1;
    @(posedge i_sys_clk);
    i_quality_valid <= 1'h0;
    rd(msc_pkg::QUALITY_OFFSET, 32'hffffffff, {24'h0, q[4:0], 3'h0}, 2'h0);
    wm(8'h88);
    wm(8'h80);
    repeat (8) @(posedge i_sys_clk);
    chk("settled", 32'(o_filters_settled), 32'h0);
    repeat (200) @(posedge i_sys_clk);
    chk("settled", 32'(o_filters_settled), 32'h1);
    wm(8'h90);
    chk("eye", 32'(o_eye_monitor), 32'h1);
    wm(8'hb0);
    chk("eye", 32'(o_eye_monitor), 32'h0);
    stop_test;
  end
endmodule : tb
